// [core/mrsc_top.sv]
// Supervisory pins: hard reset, factory default, wake, status LEDs, config pins
//
// Overview of operation
// - System status LED stays steadily lit during normal operation.
// - After default held 5 s, LED blinks with one-second period.
// - After qualifying press, wait for release, then restore defaults and reboot.
// - Wireless link LED lit only while station is associated.
// - Wireless link LED output is active low.
// - System status LED output is active high.
// - Hard reset input active low; reboots processor directly in hardware.
// - Default input sampled; low for five seconds, then released, restores defaults and reboots.
// - Rising edge on wake input resumes processor from sleep.
// - Eight configurable pins, each input or output, inputs after reset.
// - SPI mode: pin 2 irq, 3 MISO, 4 MOSI, 7 SCLK, 8 chip select.
`timescale 1ns/100ps
module mrsc_top
	import mrsc_pkg::*;
#(
	parameter int unsigned HOLD_CYC = DEFAULT_HOLD_CYC,
	parameter int unsigned BLINK_START = BLINK_START_CYC,
	parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
	parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic hard_reset_n_i,
	input wire logic factory_default_n_i,
	input wire logic wake_i,
	input wire logic sleep_req_i,
	input wire logic sta_associated_i,
	input wire logic [7:0] cp_dir_i,
	input wire logic [7:0] cp_out_i,
	input wire logic cp_cfg_valid_i,
	input wire logic spi_mode_i,
	input wire logic spi_miso_i,
	input wire logic [7:0] config_pin_in_i,
	output logic [7:0] config_pin_out_o,
	output logic [7:0] config_pin_oe_n_o,
	output logic [7:0] config_pin_sync_o,
	output mrsc_spi_in_t spi_in_o,
	output logic system_status_led_o,
	output logic wireless_link_led_n_o,
	output logic cpu_reset_o,
	output logic restore_defaults_o,
	output logic asleep_o,
	output logic wake_pulse_o
);
	localparam int unsigned HW = $clog2(HOLD_CYC + 1);
	localparam int unsigned BW = $clog2(BLINK_HALF + 1);
	localparam int unsigned PW = $clog2(REBOOT_PULSE_CYC + 1);

	logic hard_reset_n_s;
	logic default_n_s;
	logic wake_s;
	logic [7:0] cp_meta_r;
	logic [7:0] cp_sync_r;

	mrsc_sync_filter #(.SETTLE_CYC(1), .RESET_VAL(1'b1)) u_sync_hard (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(hard_reset_n_i),
		.level_o(hard_reset_n_s)
	);
	mrsc_sync_filter #(.SETTLE_CYC(DEBOUNCE), .RESET_VAL(1'b1)) u_sync_def (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(factory_default_n_i),
		.level_o(default_n_s)
	);
	mrsc_sync_filter #(.SETTLE_CYC(1), .RESET_VAL(1'b0)) u_sync_wake (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(wake_i),
		.level_o(wake_s)
	);

	// Factory-default sequence
	mrsc_def_state_t def_state_r;
	mrsc_def_state_t def_state_nxt;
	logic [HW-1:0] hold_r;
	logic [HW-1:0] hold_nxt;
	logic [BW-1:0] blink_cnt_r;
	logic [BW-1:0] blink_cnt_nxt;
	logic blink_r;
	logic blink_nxt;
	logic restore_r;
	logic restore_nxt;

	always_comb begin
		def_state_nxt = def_state_r;
		hold_nxt = hold_r;
		blink_cnt_nxt = blink_cnt_r;
		blink_nxt = blink_r;
		restore_nxt = 1'b0;
		unique case (def_state_r)
			MRSC_DEF_IDLE: begin
				hold_nxt = '0;
				blink_nxt = 1'b1;
				blink_cnt_nxt = '0;
				if (!default_n_s) begin
					def_state_nxt = MRSC_DEF_COUNT;
				end
			end
			MRSC_DEF_COUNT: begin
				if (default_n_s) begin
					def_state_nxt = MRSC_DEF_IDLE;
				end else begin
					hold_nxt = hold_r + HW'(1);
					if (hold_r >= HW'(BLINK_START - 1)) begin
						def_state_nxt = MRSC_DEF_ARMED;
						blink_nxt = 1'b0;
						blink_cnt_nxt = '0;
					end
				end
			end
			MRSC_DEF_ARMED: begin
				// Blink with a one-second period until the button lets go
				if (blink_cnt_r >= BW'(BLINK_HALF - 1)) begin
					blink_cnt_nxt = '0;
					blink_nxt = !blink_r;
				end else begin
					blink_cnt_nxt = blink_cnt_r + BW'(1);
				end
				if (!default_n_s && hold_r < HW'(HOLD_CYC)) begin
					hold_nxt = hold_r + HW'(1);
				end
				if (default_n_s) begin
					def_state_nxt = MRSC_DEF_RESTORE;
				end
			end
			MRSC_DEF_RESTORE: begin
				// Restore only once released; a short press already left via IDLE
				restore_nxt = 1'b1;
				def_state_nxt = MRSC_DEF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			def_state_r <= MRSC_DEF_IDLE;
			hold_r <= '0;
			blink_cnt_r <= '0;
			blink_r <= 1'b1;
			restore_r <= 1'b0;
		end else begin
			def_state_r <= def_state_nxt;
			hold_r <= hold_nxt;
			blink_cnt_r <= blink_cnt_nxt;
			blink_r <= blink_nxt;
			restore_r <= restore_nxt;
		end
	end

	// Reboot pulse: hard reset level or end of factory restore
	logic [PW-1:0] reboot_cnt_r;
	logic [PW-1:0] reboot_cnt_nxt;
	logic cpu_reset_r;
	logic cpu_reset_nxt;

	always_comb begin
		reboot_cnt_nxt = reboot_cnt_r;
		cpu_reset_nxt = 1'b0;
		if (!hard_reset_n_s) begin
			reboot_cnt_nxt = PW'(REBOOT_PULSE_CYC);
			cpu_reset_nxt = 1'b1;
		end else if (restore_r) begin
			reboot_cnt_nxt = PW'(REBOOT_PULSE_CYC);
			cpu_reset_nxt = 1'b1;
		end else if (reboot_cnt_r != '0) begin
			reboot_cnt_nxt = reboot_cnt_r - PW'(1);
			cpu_reset_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			reboot_cnt_r <= '0;
			cpu_reset_r <= 1'b1;
		end else begin
			reboot_cnt_r <= reboot_cnt_nxt;
			cpu_reset_r <= cpu_reset_nxt;
		end
	end

	// Sleep and wake
	logic wake_d_r;
	logic asleep_r;
	logic asleep_nxt;
	logic wake_pulse_r;
	logic wake_pulse_nxt;

	always_comb begin
		asleep_nxt = asleep_r;
		wake_pulse_nxt = 1'b0;
		if (cpu_reset_r) begin
			asleep_nxt = 1'b0;
		end else if (asleep_r && wake_s && !wake_d_r) begin
			asleep_nxt = 1'b0;
			wake_pulse_nxt = 1'b1;
		end else if (sleep_req_i) begin
			asleep_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wake_d_r <= 1'b0;
			asleep_r <= 1'b0;
			wake_pulse_r <= 1'b0;
		end else begin
			wake_d_r <= wake_s;
			asleep_r <= asleep_nxt;
			wake_pulse_r <= wake_pulse_nxt;
		end
	end

	// LEDs
	logic system_status_led_r;
	logic system_status_led_nxt;
	logic link_led_n_r;
	logic link_led_n_nxt;

	always_comb begin
		system_status_led_nxt = 1'b1;
		if (def_state_r == MRSC_DEF_ARMED) begin
			system_status_led_nxt = blink_r;
		end
		link_led_n_nxt = !sta_associated_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			system_status_led_r <= 1'b1;
			link_led_n_r <= 1'b1;
		end else begin
			system_status_led_r <= system_status_led_nxt;
			link_led_n_r <= link_led_n_nxt;
		end
	end

	// Configurable pins
	mrsc_pins_t pins_r;
	mrsc_pins_t pins_nxt;

	always_comb begin
		pins_nxt = pins_r;
		pins_nxt.in = cp_sync_r;
		if (cpu_reset_r) begin
			pins_nxt.oe_n = ~CP_DIR_RESET;
			pins_nxt.out = CP_OUT_RESET;
		end else if (cp_cfg_valid_i) begin
			pins_nxt.oe_n = ~cp_dir_i;
			pins_nxt.out = cp_out_i;
		end
		if (spi_mode_i) begin
			// Only MISO drives out; every other pin, SPI or not, is held as an input
			pins_nxt.oe_n = pins_nxt.oe_n | CP_OE_SPI_MASK;
			pins_nxt.oe_n[CP_IDX_MISO] = cpu_reset_r;
			pins_nxt.out[CP_IDX_MISO] = spi_miso_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cp_meta_r <= 8'h00;
			cp_sync_r <= 8'h00;
			pins_r.in <= 8'h00;
			pins_r.out <= CP_OUT_RESET;
			pins_r.oe_n <= ~CP_DIR_RESET;
		end else begin
			cp_meta_r <= config_pin_in_i;
			cp_sync_r <= cp_meta_r;
			pins_r <= pins_nxt;
		end
	end

	assign config_pin_out_o = pins_r.out;
	assign config_pin_oe_n_o = pins_r.oe_n;
	assign config_pin_sync_o = pins_r.in;
	assign spi_in_o = {pins_r.in[CP_IDX_SCLK], pins_r.in[CP_IDX_CS], pins_r.in[CP_IDX_MOSI], pins_r.in[CP_IDX_IRQ]};
	assign system_status_led_o = system_status_led_r;
	assign wireless_link_led_n_o = link_led_n_r;
	assign cpu_reset_o = cpu_reset_r;
	assign restore_defaults_o = restore_r;
	assign asleep_o = asleep_r;
	assign wake_pulse_o = wake_pulse_r;

	property p_hard_reset;
		@(posedge clk_sys_i) disable iff (reset_i)
		!hard_reset_n_s |=> cpu_reset_o;
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("hard reset did not reboot");
	property p_restore_reboot;
		@(posedge clk_sys_i) disable iff (reset_i)
		restore_defaults_o |=> cpu_reset_o [*8];
	endproperty
	a_restore_reboot: assert property (p_restore_reboot) else $error("restore without reboot pulse");
	property p_restore_after_release;
		@(posedge clk_sys_i) disable iff (reset_i)
		$rose(restore_defaults_o) |-> $past(default_n_s, 2) && $past(def_state_r, 2) == MRSC_DEF_ARMED;
	endproperty
	a_restore_after_release: assert property (p_restore_after_release) else $error("restore before release");
	property p_led_steady;
		@(posedge clk_sys_i) disable iff (reset_i)
		(def_state_r != MRSC_DEF_ARMED) |=> system_status_led_o;
	endproperty
	a_led_steady: assert property (p_led_steady) else $error("status LED not lit");
	property p_blink_start;
		@(posedge clk_sys_i) disable iff (reset_i)
		(def_state_r == MRSC_DEF_COUNT && def_state_nxt == MRSC_DEF_ARMED) |-> hold_r == HW'(BLINK_START - 1);
	endproperty
	a_blink_start: assert property (p_blink_start) else $error("blink started at wrong hold time");
	property p_link_led;
		@(posedge clk_sys_i) disable iff (reset_i)
		##1 (wireless_link_led_n_o == !$past(sta_associated_i));
	endproperty
	a_link_led: assert property (p_link_led) else $error("link LED wrong");
	property p_wake;
		@(posedge clk_sys_i) disable iff (reset_i)
		(asleep_r && !cpu_reset_r && $rose(wake_s)) |=> !asleep_o && wake_pulse_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake edge ignored");
	property p_reset_inputs;
		@(posedge clk_sys_i) disable iff (reset_i)
		cpu_reset_r && !spi_mode_i |=> config_pin_oe_n_o == 8'hFF;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pin not input after reset");
	property p_spi_dirs;
		@(posedge clk_sys_i) disable iff (reset_i)
		spi_mode_i |=> (config_pin_oe_n_o & CP_OE_SPI_MASK) == CP_OE_SPI_MASK;
	endproperty
	a_spi_dirs: assert property (p_spi_dirs) else $error("SPI input pin driven");
endmodule

// [core/mrsc_pkg.sv]
// Constants and carrier types for the module reset and status control block
package mrsc_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CP_COUNT = 8;
	// Factory-default hold time in ms, where the hold count saturates; release restores from BLINK_START_MS on
	localparam int unsigned DEFAULT_HOLD_MS = 6000;
	localparam int unsigned DEFAULT_HOLD_CYC = (CLK_HZ / 1000) * DEFAULT_HOLD_MS;
	// Blink indication begins at the lower end of the press window
	localparam int unsigned BLINK_START_MS = 5000;
	localparam int unsigned BLINK_START_CYC = (CLK_HZ / 1000) * BLINK_START_MS;
	// One-second blink period, half high and half low
	localparam int unsigned BLINK_HALF_MS = 500;
	localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
	// Debounce settle time in ms
	localparam int unsigned DEBOUNCE_MS = 10;
	localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
	// Length of the internal reboot pulse, cycles
	localparam int unsigned REBOOT_PULSE_CYC = 16;
	// Pin indices (zero based) of the SPI functions
	localparam int unsigned CP_IDX_IRQ = 1;
	localparam int unsigned CP_IDX_MISO = 2;
	localparam int unsigned CP_IDX_MOSI = 3;
	localparam int unsigned CP_IDX_SCLK = 6;
	localparam int unsigned CP_IDX_CS = 7;
	localparam logic [7:0] CP_DIR_RESET = 8'h00;
	localparam logic [7:0] CP_OUT_RESET = 8'h00;
	localparam logic [7:0] CP_OE_SPI_MASK = 8'hFB;

	typedef enum logic [1:0] {
		MRSC_DEF_IDLE,
		MRSC_DEF_COUNT,
		MRSC_DEF_ARMED,
		MRSC_DEF_RESTORE
	} mrsc_def_state_t;

	typedef struct packed {
		logic [7:0] in;
		logic [7:0] out;
		logic [7:0] oe_n;
	} mrsc_pins_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
		logic irq;
	} mrsc_spi_in_t;
endpackage

// [core/mrsc_sync_filter.sv]
// Two-stage synchroniser with optional debounce filter
`timescale 1ns/100ps
module mrsc_sync_filter #(
	parameter int unsigned SETTLE_CYC = 1,
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic level_o
);
	localparam int unsigned CW = $clog2(SETTLE_CYC + 1);
	logic meta_r;
	logic sync_r;
	logic level_r;
	logic level_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	always_comb begin
		level_nxt = level_r;
		cnt_nxt = cnt_r;
		if (sync_r == level_r) begin
			cnt_nxt = '0;
		end else if (cnt_r >= CW'(SETTLE_CYC - 1)) begin
			level_nxt = sync_r;
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
			level_r <= RESET_VAL;
			cnt_r <= '0;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
			level_r <= level_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign level_o = level_r;
endmodule

// [tb/mrsc_host_model.sv]
// Host board model: buttons, wake line, pin drivers and LED view
`timescale 1ns/100ps
module mrsc_host_model (
	input wire logic rst_press_i,
	input wire logic def_press_i,
	input wire logic wake_lvl_i,
	input wire logic [7:0] pin_ext_i,
	input wire logic [7:0] pin_out_i,
	input wire logic [7:0] pin_oe_n_i,
	input wire logic system_status_led_i,
	input wire logic link_led_n_i,
	output logic hard_reset_n_o,
	output logic factory_default_n_o,
	output logic wake_o,
	output logic [7:0] pin_lvl_o,
	output logic sys_lit_o,
	output logic link_lit_o
);
	// Released reset line floats up through its pull-up
	assign hard_reset_n_o = !rst_press_i;
	assign factory_default_n_o = !def_press_i;
	assign wake_o = wake_lvl_i;
	// Device driver wins where its enable is low
	assign pin_lvl_o = (pin_out_i & ~pin_oe_n_i) | (pin_ext_i & pin_oe_n_i);
	assign sys_lit_o = system_status_led_i;
	assign link_lit_o = !link_led_n_i;
endmodule

// [tb/mrsc_top_bench.sv]
// Self-checking bench for the supervisory pin block
`timescale 1ns/100ps
module mrsc_top_bench;
	import mrsc_pkg::*;
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] out;
		logic [7:0] ext;
		logic spi;
		logic miso;
		logic assoc;
		logic [7:0] oe_n;
		logic [7:0] out_m;
		logic [7:0] out_x;
		logic [7:0] sync;
		logic [3:0] spi_x;
	} mrsc_row_t;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic rst_press = 1'b0;
	logic def_press = 1'b0;
	logic wake_lvl = 1'b0;
	logic sleep_req = 1'b0;
	logic assoc = 1'b0;
	logic cfg_v = 1'b0;
	logic spi = 1'b0;
	logic miso = 1'b0;
	logic [7:0] dir = 8'h00;
	logic [7:0] outv = 8'h00;
	logic [7:0] ext = 8'h00;
	logic hard_n, def_n, wake, system_status_led, link_n, sys_lit, link_lit, cpu_rst, restore, asleep, wake_p, prev;
	logic [7:0] pin_lvl, pin_out, pin_oe_n, pin_sync;
	mrsc_spi_in_t spi_in;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_rest = 0;
	int n_wake = 0;
	int hi, rise;
	mrsc_row_t rows [5];

	mrsc_top #(.HOLD_CYC(200), .BLINK_START(100), .BLINK_HALF(10), .DEBOUNCE(2)) dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hard_reset_n_i(hard_n), .factory_default_n_i(def_n),
		.wake_i(wake), .sleep_req_i(sleep_req), .sta_associated_i(assoc), .cp_dir_i(dir), .cp_out_i(outv),
		.cp_cfg_valid_i(cfg_v), .spi_mode_i(spi), .spi_miso_i(miso), .config_pin_in_i(pin_lvl),
		.config_pin_out_o(pin_out), .config_pin_oe_n_o(pin_oe_n), .config_pin_sync_o(pin_sync),
		.spi_in_o(spi_in), .system_status_led_o(system_status_led), .wireless_link_led_n_o(link_n),
		.cpu_reset_o(cpu_rst), .restore_defaults_o(restore), .asleep_o(asleep), .wake_pulse_o(wake_p));
	mrsc_host_model host (
		.rst_press_i(rst_press), .def_press_i(def_press), .wake_lvl_i(wake_lvl), .pin_ext_i(ext),
		.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n), .system_status_led_i(system_status_led), .link_led_n_i(link_n),
		.hard_reset_n_o(hard_n), .factory_default_n_o(def_n), .wake_o(wake), .pin_lvl_o(pin_lvl),
		.sys_lit_o(sys_lit), .link_lit_o(link_lit));

	always #25 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (restore === 1'b1) n_rest <= n_rest + 1;
		if (wake_p === 1'b1) n_wake <= n_wake + 1;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic cfg(input logic [7:0] d, input logic [7:0] o);
		dir = d;
		outv = o;
		cfg_v = 1'b1;
		tick(1);
		cfg_v = 1'b0;
	endtask
	task automatic close_out;
		if (fails == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Run needs about 410 cycles; a hang is cut well after that
	always @(negedge clk_sys_i) begin
		if (cyc >= 3000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		rows[0] = {8'h00, 8'h00, 8'hA5, 1'b0, 1'b0, 1'b1, 8'hFF, 8'h00, 8'h00, 8'hA5, 4'h0};
		rows[1] = {8'hFF, 8'h3C, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 8'hFF, 8'h3C, 8'h3C, 4'h0};
		rows[2] = {8'h0F, 8'h5A, 8'hF0, 1'b0, 1'b0, 1'b1, 8'hF0, 8'h0F, 8'h0A, 8'hFA, 4'h0};
		rows[3] = {8'hFF, 8'hFF, 8'h42, 1'b1, 1'b1, 1'b0, 8'hFB, 8'h04, 8'h04, 8'h46, 4'h9};
		rows[4] = {8'h00, 8'h00, 8'h8A, 1'b1, 1'b0, 1'b1, 8'hFB, 8'h04, 8'h00, 8'h8A, 4'h7};
		tick(16);
		chk8(pin_oe_n, 8'hFF);
		chk1(cpu_rst, 1'b1);
		chk1(link_lit, 1'b0);
		chk1(sys_lit, 1'b1);
		reset_i = 1'b0;
		tick(3);
		chk1(cpu_rst, 1'b0);
		foreach (rows[i]) begin
			spi = rows[i].spi;
			miso = rows[i].miso;
			assoc = rows[i].assoc;
			ext = rows[i].ext;
			cfg(rows[i].dir, rows[i].out);
			tick(5);
			chk8(pin_oe_n, rows[i].oe_n);
			chk8(pin_out & rows[i].out_m, rows[i].out_x);
			chk8(pin_sync, rows[i].sync);
			chk1(link_lit, rows[i].assoc);
			if (rows[i].spi) chk8({4'h0, spi_in}, {4'h0, rows[i].spi_x});
		end
		chk1(sys_lit, 1'b1);
		spi = 1'b0;
		def_press = 1'b1;
		tick(50);
		def_press = 1'b0;
		tick(30);
		chk8(n_rest[7:0], 8'h00);
		chk1(cpu_rst, 1'b0);
		def_press = 1'b1;
		tick(95);
		chk1(sys_lit, 1'b1);
		tick(20);
		hi = 0;
		rise = 0;
		prev = sys_lit;
		repeat (40) begin
			tick(1);
			hi = hi + int'(sys_lit);
			rise = rise + int'(sys_lit && !prev);
			prev = sys_lit;
		end
		chk8(hi[7:0], 8'h14);
		chk8(rise[7:0], 8'h02);
		chk8(n_rest[7:0], 8'h00);
		def_press = 1'b0;
		tick(15);
		chk8(n_rest[7:0], 8'h01);
		chk1(cpu_rst, 1'b1);
		tick(30);
		chk1(cpu_rst, 1'b0);
		chk1(sys_lit, 1'b1);
		cfg(8'h00, 8'h00);
		tick(2);
		rst_press = 1'b1;
		tick(1);
		chk1(cpu_rst, 1'b0);
		tick(5);
		chk1(cpu_rst, 1'b1);
		// Config and the MISO drive are both held off while the processor is in reset
		cfg(8'hFF, 8'hFF);
		spi = 1'b1;
		tick(24);
		chk8(pin_oe_n, 8'hFF);
		spi = 1'b0;
		rst_press = 1'b0;
		tick(10);
		chk1(cpu_rst, 1'b1);
		tick(20);
		chk1(cpu_rst, 1'b0);
		chk8(pin_oe_n, 8'hFF);
		wake_lvl = 1'b1;
		tick(8);
		chk8(n_wake[7:0], 8'h00);
		wake_lvl = 1'b0;
		sleep_req = 1'b1;
		tick(1);
		sleep_req = 1'b0;
		tick(3);
		chk1(asleep, 1'b1);
		wake_lvl = 1'b1;
		tick(8);
		chk8(n_wake[7:0], 8'h01);
		chk1(asleep, 1'b0);
		close_out();
	end
endmodule
